// ===== include/smb_defines.svh
/*
  constants for the two-wire slave with alert response and its bus master
  assumes a 250 MHz clk_in on both ends and pull-ups on the shared lines
*/
// Summary of operation
// [R1] primary address 010 plus four strap pins
// [R2] broadcast address 0110000 also accepted for writes
// [R3] alert response address acknowledged only while interrupting
// [R4] only write, read and receive byte transactions
// [R5] lines idle high; start and stop detected
// [R6] acknowledge held low through clock high phase
// [R7] master clocks acknowledge and releases data line
// [R8] master reads end with no-acknowledge then stop
// [R9] command byte low five bits load pointer
// [R10] data byte acknowledged and written at pointer
// [R11] pointer cleared on every stop
// [R12] read: write address, command, restart, read address
// [R13] receive byte returns register zero
// [R14] alert response sends own address and one
// [R15] losing arbitration aborts alert response immediately
// [R16] completed alert response releases interrupt output
// [R17] register 1ah bit 6 releases interrupt
// [R18] released interrupt waits until cause removed; the code also re-arms it when register 1ah is written with bit 7 set and bit 6 clear
// [R19] interrupt changes only between transactions
// [R20] separate data input and open-drain output pins
// [R21] start at power-up holds interrupt until stop
// [R22] unknown address left unacknowledged, ignored until start
`ifndef SMB_DEFINES_SVH
`define SMB_DEFINES_SVH

`define SMB_PRIMARY_HI        3'h2
`define SMB_BCAST_ADDR        7'h30
`define SMB_ARA_ADDR          7'h0c
`define SMB_IRQ_CTRL_REG      5'h1a
`define SMB_IRQ_RELEASE_BIT   6
`define SMB_IRQ_CLEAR_ALL_BIT 7
`define SMB_CLK_PERIOD_NS     4
`define SMB_SCL_QUARTER_NS    48
`define SMB_SCL_QUARTER_CYC   ((`SMB_SCL_QUARTER_NS + `SMB_CLK_PERIOD_NS - 1) / `SMB_CLK_PERIOD_NS)

`endif

// ===== include/smb_pkg.sv
/*
  types shared by both ends: states, commands and the state records
  assumes smb_defines.svh is on the include path
*/
`include "smb_defines.svh"
package smb_pkg;

  typedef enum logic [1:0] {CMD_WRITE, CMD_READ, CMD_RECEIVE, CMD_ARA} cmd_kind_e;

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_CMD, S_DATA, S_ACK, S_TX, S_TX_ACK, S_IGNORE
  } slv_state_e;

  typedef enum logic [2:0] {M_IDLE, M_START, M_OP, M_BIT, M_RSTART, M_STOP} mst_state_e;

  typedef enum logic [2:0] {
    OP_ADDR_W, OP_CMD, OP_DATA, OP_RSTART, OP_ADDR_R, OP_RX, OP_STOP
  } op_e;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] prev;
  } line_s;

  typedef struct packed {
    slv_state_e st;
    slv_state_e after;
    logic       ara;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [4:0] ptr;
    logic       sda_oe;
    logic       irq_oe;
    logic       busy;
    logic       released;
    logic       wr_stb;
    logic [7:0] wr_data;
    logic [3:0] ad_meta;
    logic [3:0] ad;
  } slv_s;

  typedef struct packed {
    mst_state_e st;
    cmd_kind_e  kind;
    logic [2:0] step;
    logic [1:0] ph;
    logic [9:0] q;
    logic [3:0] bitcnt;
    logic       rx;
    logic       abort;
    logic [7:0] sh;
    logic [6:0] addr;
    logic [7:0] cmd;
    logic [7:0] data;
    logic       scl_oe;
    logic       sda_oe;
    logic       ready;
    logic       done;
    logic       nack;
    logic [7:0] rd_data;
    logic [1:0] alert_sync;
  } mst_s;

endpackage : smb_pkg

// ===== include/smb_if.sv
/*
  the shared two-wire link; every pin is open drain, enable high pulls low
  assumes the bench joins the device and host modports of one instance
*/
interface smb_if;
  logic scl_oe;
  logic host_sda_oe;
  logic serial_data_output_pin_oe;
  logic alert_oe;
  wire  scl                   = ~scl_oe;
  wire  serial_data_input_pin = ~(host_sda_oe | serial_data_output_pin_oe);
  wire  alert_n               = ~alert_oe;

  modport device (
    input  scl,
    input  serial_data_input_pin,
    output serial_data_output_pin_oe,
    output alert_oe
  );

  modport host (
    input  serial_data_input_pin,
    input  alert_n,
    output scl_oe,
    output host_sda_oe
  );
endinterface : smb_if

// ===== design/smb_line_sync.sv
/*
  two-stage synchroniser for clock and data lines with start/stop and edge detection
  assumes both lines come from outside the clk_in domain
*/
module smb_line_sync (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic srst_in,
  // raw lines
  input  wire logic scl_in,
  input  wire logic sda_in,
  // conditioned lines
  output logic      scl_out,
  output logic      sda_out,
  output logic      scl_rise_out,
  output logic      scl_fall_out,
  output logic      start_out,
  output logic      stop_out
);
  smb_pkg::line_s r;
  smb_pkg::line_s n;

  always_comb begin
    n      = r;
    n.meta = {scl_in, sda_in};
    n.sync = r.meta;
    n.prev = r.sync;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r <= '{meta: 2'h3, sync: 2'h3, prev: 2'h3};
    end else begin
      r <= n;
    end
  end

  // start and stop: data edge while clock stays high
  assign scl_out      = r.sync[1];
  assign sda_out      = r.sync[0];
  assign scl_rise_out = r.sync[1] & ~r.prev[1];
  assign scl_fall_out = ~r.sync[1] & r.prev[1];
  assign start_out    = r.sync[1] & r.prev[1] & r.prev[0] & ~r.sync[0]; // [R5]
  assign stop_out     = r.sync[1] & r.prev[1] & ~r.prev[0] & r.sync[0]; // [R5]
endmodule : smb_line_sync

// ===== design/smb_slave.sv
/*
  device end: two-wire slave with pointer, write strobe and alert response
  assumes rd_data_in answers rd_addr_out in the same cycle; irq_cause_in is on clk_in
*/
`include "smb_defines.svh"
module smb_slave (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  // link
  smb_if.device           bus,
  // address straps
  input  wire logic [3:0] slave_address_select_pins_in,
  // register read port
  output logic      [4:0] rd_addr_out,
  input  wire logic [7:0] rd_data_in,
  // register write port
  output logic            wr_strobe_out,
  output logic      [4:0] wr_addr_out,
  output logic      [7:0] wr_data_out,
  // interrupt
  input  wire logic       irq_cause_in,
  output logic            irq_active_out
);
  smb_pkg::slv_s r;
  smb_pkg::slv_s n;

  logic       scl_lvl;
  logic       sda;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic [6:0] prim;
  logic [7:0] tx_byte;
  logic       hit_pri;
  logic       hit_bc;
  logic       hit_ara;

  smb_line_sync u_sync (
    .clk_in       (clk_in),
    .srst_in      (srst_in),
    .scl_in       (bus.scl),
    .sda_in       (bus.serial_data_input_pin), // [R20]
    .scl_out      (scl_lvl),
    .sda_out      (sda),
    .scl_rise_out (rise),
    .scl_fall_out (fall),
    .start_out    (start),
    .stop_out     (stop)
  );

  assign prim    = {`SMB_PRIMARY_HI, r.ad}; // [R1]
  assign tx_byte = r.ara ? {prim, 1'b1} : rd_data_in; // [R14]
  assign hit_pri = r.sh[7:1] == prim; // [R1]
  assign hit_bc  = (r.sh[7:1] == `SMB_BCAST_ADDR) && !r.sh[0]; // [R2]
  assign hit_ara = (r.sh[7:1] == `SMB_ARA_ADDR) && r.sh[0] && r.irq_oe; // [R3]

  always_comb begin
    n         = r;
    n.wr_stb  = 1'b0;
    n.ad_meta = slave_address_select_pins_in;
    n.ad      = r.ad_meta;
    if (!irq_cause_in) begin
      n.released = 1'b0; // [R18]
    end
    if (start) begin
      n.st     = smb_pkg::S_ADDR; // [R5]
      n.cnt    = 4'h0;
      n.sda_oe = 1'b0;
      n.busy   = 1'b1;
      n.ara    = 1'b0;
    end else if (stop) begin
      n.st     = smb_pkg::S_IDLE; // [R5]
      n.ptr    = 5'h00; // [R11]
      n.sda_oe = 1'b0;
      n.busy   = 1'b0;
    end else begin
      case (r.st)
        smb_pkg::S_ADDR, smb_pkg::S_CMD, smb_pkg::S_DATA: begin
          if (rise) begin
            n.sh  = {r.sh[6:0], sda};
            n.cnt = r.cnt + 4'h1;
          end else if (fall && r.cnt == 4'h8) begin
            n.st     = smb_pkg::S_ACK;
            n.sda_oe = 1'b1; // [R6]
            n.cnt    = 4'h0;
            if (r.st == smb_pkg::S_ADDR) begin
              if (hit_ara) begin
                n.ara   = 1'b1; // [R3]
                n.after = smb_pkg::S_TX;
              end else if (hit_pri || hit_bc) begin
                n.after = r.sh[0] ? smb_pkg::S_TX : smb_pkg::S_CMD; // [R12] [R13]
              end else begin
                n.st     = smb_pkg::S_IGNORE; // [R22]
                n.sda_oe = 1'b0;
              end
            end else if (r.st == smb_pkg::S_CMD) begin
              n.ptr   = r.sh[4:0]; // [R9]
              n.after = smb_pkg::S_DATA;
            end else begin
              n.wr_stb  = 1'b1; // [R10]
              n.wr_data = r.sh;
              n.after   = smb_pkg::S_IGNORE;
              if (r.ptr == `SMB_IRQ_CTRL_REG) begin
                if (r.sh[`SMB_IRQ_CLEAR_ALL_BIT]) begin
                  n.released = 1'b0; // [R18]
                end
                if (r.sh[`SMB_IRQ_RELEASE_BIT]) begin
                  n.released = 1'b1; // [R17]
                end
              end
            end
          end
        end
        smb_pkg::S_ACK: begin
          if (fall) begin
            n.sda_oe = 1'b0; // [R6]
            n.st     = r.after;
            n.cnt    = 4'h0;
            if (r.after == smb_pkg::S_TX) begin
              n.sh     = tx_byte; // [R13] [R14]
              n.sda_oe = ~tx_byte[7];
            end
          end
        end
        smb_pkg::S_TX: begin
          if (rise) begin
            if (r.ara && !r.sda_oe && !sda) begin
              n.st     = smb_pkg::S_IGNORE; // [R15]
              n.sda_oe = 1'b0;
            end else begin
              n.cnt = r.cnt + 4'h1;
            end
          end else if (fall) begin
            if (r.cnt == 4'h8) begin
              n.sda_oe = 1'b0;
              n.st     = smb_pkg::S_TX_ACK;
            end else begin
              n.sh     = {r.sh[6:0], 1'b0};
              n.sda_oe = ~r.sh[6];
            end
          end
        end
        smb_pkg::S_TX_ACK: begin
          if (rise) begin
            if (r.ara) begin
              n.released = 1'b1; // [R16]
            end
            if (sda || r.ara) begin
              n.st = smb_pkg::S_IGNORE;
            end
          end else if (fall) begin
            n.st     = smb_pkg::S_TX;
            n.cnt    = 4'h0;
            n.sh     = tx_byte;
            n.sda_oe = ~tx_byte[7];
          end
        end
        default: begin
          n.st = r.st;
        end
      endcase
    end
    if (!r.busy && !start) begin
      n.irq_oe = irq_cause_in & ~n.released; // [R19] [R21] [R18]
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign bus.serial_data_output_pin_oe = r.sda_oe; // [R20]
  assign bus.alert_oe                  = r.irq_oe;
  assign rd_addr_out                   = r.ptr;
  assign wr_strobe_out                 = r.wr_stb;
  assign wr_addr_out                   = r.ptr;
  assign wr_data_out                   = r.wr_data;
  assign irq_active_out                = r.irq_oe;
endmodule : smb_slave

// ===== design/smb_master.sv
/*
  host end: bus master issuing write, read, receive and alert response transfers
  assumes one command at a time on the user port and no clock stretching
*/
`include "smb_defines.svh"
module smb_master (
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               srst_in,
  // link
  smb_if.host                     bus,
  // command port
  input  wire logic               cmd_valid_in,
  input  wire smb_pkg::cmd_kind_e cmd_kind_in,
  input  wire logic [6:0]         cmd_addr_in,
  input  wire logic [7:0]         cmd_reg_in,
  input  wire logic [7:0]         cmd_data_in,
  output logic                    cmd_ready_out,
  // result
  output logic                    done_out,
  output logic                    nack_out,
  output logic [7:0]              rd_data_out,
  output logic                    alert_out
);
  localparam logic [9:0] QUARTER = 10'(`SMB_SCL_QUARTER_CYC);

  smb_pkg::mst_s r;
  smb_pkg::mst_s n;
  smb_pkg::op_e  op;
  logic          sda;
  logic          tick;

  smb_line_sync u_sync (
    .clk_in       (clk_in),
    .srst_in      (srst_in),
    .scl_in       (~r.scl_oe),
    .sda_in       (bus.serial_data_input_pin),
    .scl_out      (),
    .sda_out      (sda),
    .scl_rise_out (),
    .scl_fall_out (),
    .start_out    (),
    .stop_out     ()
  );

  assign tick = r.q == QUARTER - 10'h001;

  // byte plan of each transaction kind
  always_comb begin
    op = smb_pkg::OP_STOP;
    case (r.kind)
      smb_pkg::CMD_WRITE: begin
        case (r.step)
          3'h0:    op = smb_pkg::OP_ADDR_W; // [R4]
          3'h1:    op = smb_pkg::OP_CMD;
          3'h2:    op = smb_pkg::OP_DATA;
          default: op = smb_pkg::OP_STOP;
        endcase
      end
      smb_pkg::CMD_READ: begin
        case (r.step)
          3'h0:    op = smb_pkg::OP_ADDR_W; // [R12]
          3'h1:    op = smb_pkg::OP_CMD;
          3'h2:    op = smb_pkg::OP_RSTART;
          3'h3:    op = smb_pkg::OP_ADDR_R;
          3'h4:    op = smb_pkg::OP_RX;
          default: op = smb_pkg::OP_STOP;
        endcase
      end
      default: begin
        case (r.step)
          3'h0:    op = smb_pkg::OP_ADDR_R; // [R4]
          3'h1:    op = smb_pkg::OP_RX;
          default: op = smb_pkg::OP_STOP;
        endcase
      end
    endcase
  end

  always_comb begin
    n            = r;
    n.done       = 1'b0;
    n.alert_sync = {r.alert_sync[0], ~bus.alert_n};
    n.q          = (r.st == smb_pkg::M_IDLE || tick) ? 10'h000 : r.q + 10'h001;
    case (r.st)
      smb_pkg::M_IDLE: begin
        n.ready = 1'b1;
        if (cmd_valid_in) begin
          n.ready = 1'b0;
          n.kind  = cmd_kind_in;
          n.addr  = (cmd_kind_in == smb_pkg::CMD_ARA) ? `SMB_ARA_ADDR : cmd_addr_in;
          n.cmd   = cmd_reg_in;
          n.data  = cmd_data_in;
          n.step  = 3'h0;
          n.ph    = 2'h0;
          n.nack  = 1'b0;
          n.abort = 1'b0;
          n.st    = smb_pkg::M_START;
        end
      end
      smb_pkg::M_START: begin
        if (tick) begin
          n.ph = r.ph + 2'h1;
          if (r.ph == 2'h0) begin
            n.sda_oe = 1'b1; // [R5]
          end else begin
            n.scl_oe = 1'b1;
            n.st     = smb_pkg::M_OP;
          end
        end
      end
      smb_pkg::M_OP: begin
        n.step   = r.step + 3'h1;
        n.ph     = 2'h0;
        n.bitcnt = 4'h0;
        n.rx     = op == smb_pkg::OP_RX;
        case (op)
          smb_pkg::OP_ADDR_W: n.sh = {r.addr, 1'b0};
          smb_pkg::OP_ADDR_R: n.sh = {r.addr, 1'b1};
          smb_pkg::OP_CMD:    n.sh = r.cmd;
          smb_pkg::OP_DATA:   n.sh = r.data;
          default:            n.sh = 8'hff;
        endcase
        if (op == smb_pkg::OP_RSTART) begin
          n.st = smb_pkg::M_RSTART;
        end else if (op == smb_pkg::OP_STOP) begin
          n.st = smb_pkg::M_STOP;
        end else begin
          n.st = smb_pkg::M_BIT;
        end
      end
      smb_pkg::M_BIT: begin
        if (tick) begin
          n.ph = r.ph + 2'h1;
          case (r.ph)
            2'h0: n.sda_oe = !r.rx && r.bitcnt != 4'h8 && !r.sh[7]; // [R7] [R8]
            2'h1: n.scl_oe = 1'b0;
            2'h2: begin
              if (r.bitcnt != 4'h8) begin
                n.sh = {r.sh[6:0], sda};
              end else if (!r.rx && sda) begin
                n.abort = 1'b1;
                n.nack  = 1'b1;
              end
            end
            default: begin
              n.scl_oe = 1'b1;
              n.bitcnt = r.bitcnt + 4'h1;
              if (r.bitcnt == 4'h8) begin
                if (r.rx) begin
                  n.rd_data = r.sh;
                end
                n.st = r.abort ? smb_pkg::M_STOP : smb_pkg::M_OP;
              end
            end
          endcase
        end
      end
      smb_pkg::M_RSTART: begin
        if (tick) begin
          n.ph = r.ph + 2'h1;
          case (r.ph)
            2'h0: n.sda_oe = 1'b0;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b1;
            default: begin
              n.scl_oe = 1'b1;
              n.st     = smb_pkg::M_OP;
            end
          endcase
        end
      end
      smb_pkg::M_STOP: begin
        if (tick) begin
          n.ph = r.ph + 2'h1;
          case (r.ph)
            2'h0: n.sda_oe = 1'b1;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b0; // [R5] [R8]
            default: begin
              n.done  = 1'b1;
              n.ready = 1'b1;
              n.st    = smb_pkg::M_IDLE;
            end
          endcase
        end
      end
      default: n.st = smb_pkg::M_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign bus.scl_oe      = r.scl_oe;
  assign bus.host_sda_oe = r.sda_oe;
  assign cmd_ready_out   = r.ready;
  assign done_out        = r.done;
  assign nack_out        = r.nack;
  assign rd_data_out     = r.rd_data;
  assign alert_out       = r.alert_sync[1];
endmodule : smb_master

// ===== sim/smbus_slave_with_alert_response_props.sv
/*
  concurrent checks on the link that joins the master end and the slave end
  assumes the bench feeds the plain signals of that one link instance
*/
module smbus_slave_with_alert_response_props (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // link
  input wire logic scl_oe,
  input wire logic host_sda_oe,
  input wire logic serial_data_output_pin_oe,
  input wire logic alert_oe,
  input wire logic scl,
  input wire logic serial_data_input_pin
);
  logic prev_scl_reg;
  logic prev_sda_reg;
  logic busy_reg;
  logic start_w;
  logic stop_w;

  // start and stop seen on the wire itself
  assign start_w = prev_scl_reg & scl & prev_sda_reg & ~serial_data_input_pin;
  assign stop_w  = prev_scl_reg & scl & ~prev_sda_reg & serial_data_input_pin;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      prev_scl_reg <= 1'b1;
      prev_sda_reg <= 1'b1;
      busy_reg     <= 1'b0;
    end else begin
      prev_scl_reg <= scl;
      prev_sda_reg <= serial_data_input_pin;
      busy_reg     <= start_w | (busy_reg & ~stop_w);
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  sequence ack_rise;
    $rose(scl) && serial_data_output_pin_oe;
  endsequence
  sequence ack_hold;
    !serial_data_input_pin [*8];
  endsequence
  sequence scl_up;
    $rose(scl) && busy_reg;
  endsequence

  AST_DEV_SDA_MOVES_LOW: assert property (
    $changed(serial_data_output_pin_oe) |-> !scl)
    else $error("device data output moved while clock high");
  AST_ACK_HELD_LOW: assert property (ack_rise |-> ack_hold)
    else $error("acknowledge not held low in clock high phase");
  AST_ALERT_BETWEEN: assert property (
    $changed(alert_oe) |-> !(busy_reg && $past(busy_reg, 5)))
    else $error("interrupt line moved inside a transaction");
  AST_HOST_SDA_FRAMING: assert property (
    $changed(host_sda_oe) && scl && prev_scl_reg |-> start_w || stop_w)
    else $error("host data change in clock high that is not start or stop");
  AST_NO_CONTENTION: assert property (
    scl |-> !(host_sda_oe && serial_data_output_pin_oe))
    else $error("both ends pull data low in clock high phase");
  AST_IDLE_RELEASED: assert property (
    !busy_reg |-> scl && !serial_data_output_pin_oe)
    else $error("lines not released while bus idle");
  AST_SCL_HIGH_PHASE: assert property (scl_up |-> scl [*8])
    else $error("clock high phase too short");
  AST_RESET_RELEASE: assert property (
    $fell(srst_in) |-> !scl_oe && !host_sda_oe && !serial_data_output_pin_oe && !alert_oe)
    else $error("lines driven right after reset");
endmodule : smbus_slave_with_alert_response_props

// ===== sim/smbus_slave_with_alert_response_bench.sv
/*
  bench: master end and slave end joined by one link, a second slave on a mirror link
  assumes the default bit timing of both ends and a plain register file model
*/
module smbus_slave_with_alert_response_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TIMEOUT_CYCLES = 20000;
  localparam logic [3:0] STRAP_A = 4'h0;
  localparam logic [3:0] STRAP_B = 4'h1;

  logic               clk_in       = 1'b0;
  logic               srst_in      = 1'b1;
  logic               irq_cause_in = 1'b0;
  logic               cmd_valid_in = 1'b0;
  smb_pkg::cmd_kind_e cmd_kind_in  = smb_pkg::CMD_WRITE;
  logic [6:0]         cmd_addr_in  = 7'h00;
  logic [7:0]         cmd_reg_in   = 8'h00;
  logic [7:0]         cmd_data_in  = 8'h00;
  logic               cmd_ready_out;
  logic               done_out;
  logic               nack_out;
  logic [7:0]         rd_data_out;
  logic               alert_out;
  logic [4:0]         rd_addr_out;
  logic               wr_strobe_out;
  logic [4:0]         wr_addr_out;
  logic [7:0]         wr_data_out;
  logic               irq_active_out;
  logic               irq_active_b;
  logic [7:0]         regs [32] = '{0: 8'ha7, default: 8'h00};
  int                 err_total = 0;
  int                 checks    = 0;
  int                 cycles    = 0;

  always #2 clk_in = ~clk_in;

  smb_if bus();
  smb_if bus_b();
  // second slave sees the first link; its own pull stays off the first link
  assign bus_b.scl_oe      = bus.scl_oe;
  assign bus_b.host_sda_oe = bus.host_sda_oe | bus.serial_data_output_pin_oe;

  smb_master i_smb_master (.clk_in(clk_in), .srst_in(srst_in), .bus(bus.host),
    .cmd_valid_in(cmd_valid_in), .cmd_kind_in(cmd_kind_in), .cmd_addr_in(cmd_addr_in),
    .cmd_reg_in(cmd_reg_in), .cmd_data_in(cmd_data_in), .cmd_ready_out(cmd_ready_out),
    .done_out(done_out), .nack_out(nack_out), .rd_data_out(rd_data_out),
    .alert_out(alert_out));
  smb_slave i_smb_slave (.clk_in(clk_in), .srst_in(srst_in), .bus(bus.device),
    .slave_address_select_pins_in(STRAP_A), .rd_addr_out(rd_addr_out),
    .rd_data_in(regs[rd_addr_out]), .wr_strobe_out(wr_strobe_out),
    .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out), .irq_cause_in(irq_cause_in),
    .irq_active_out(irq_active_out));
  smb_slave i_smb_slave_b (.clk_in(clk_in), .srst_in(srst_in), .bus(bus_b.device),
    .slave_address_select_pins_in(STRAP_B), .rd_addr_out(), .rd_data_in(8'h00),
    .wr_strobe_out(), .wr_addr_out(), .wr_data_out(), .irq_cause_in(irq_cause_in),
    .irq_active_out(irq_active_b));
  smbus_slave_with_alert_response_props i_props (.clk_in(clk_in), .srst_in(srst_in),
    .scl_oe(bus.scl_oe), .host_sda_oe(bus.host_sda_oe),
    .serial_data_output_pin_oe(bus.serial_data_output_pin_oe), .alert_oe(bus.alert_oe),
    .scl(bus.scl), .serial_data_input_pin(bus.serial_data_input_pin));

  // register file behind the slave
  always @(posedge clk_in) begin
    if (wr_strobe_out === 1'b1) begin
      regs[wr_addr_out] <= wr_data_out;
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == TIMEOUT_CYCLES) begin
      err_total++;
      summarize();
    end
  end

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte

  task automatic check_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  // one whole transfer on the command port, back when done pulses
  task automatic run_cmd(input smb_pkg::cmd_kind_e kind, input logic [6:0] addr,
                         input logic [7:0] rg, input logic [7:0] dat);
    while (cmd_ready_out !== 1'b1) begin
      @(posedge clk_in);
      #1;
    end
    cmd_kind_in  = kind;
    cmd_addr_in  = addr;
    cmd_reg_in   = rg;
    cmd_data_in  = dat;
    cmd_valid_in = 1'b1;
    @(posedge clk_in);
    #1;
    cmd_valid_in = 1'b0;
    while (done_out !== 1'b1) begin
      @(posedge clk_in);
      #1;
    end
  endtask : run_cmd

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : idle

  initial begin
    idle(3);
    srst_in = 1'b0;
    idle(6);
    // receive byte from the strapped address
    run_cmd(smb_pkg::CMD_RECEIVE, {3'h2, STRAP_A}, 8'h00, 8'h00);
    check_bit("receive nack", 1'b0, nack_out);
    check_byte("receive data", 8'ha7, rd_data_out);
    $display("test receive done");
    // alert response with two ends interrupting
    irq_cause_in = 1'b1;
    idle(10);
    check_bit("alert seen", 1'b1, alert_out);
    run_cmd(smb_pkg::CMD_ARA, 7'h00, 8'h00, 8'h00);
    check_bit("ara nack", 1'b0, nack_out);
    check_byte("ara data", {3'h2, STRAP_A, 1'b1}, rd_data_out);
    idle(10);
    check_bit("winner alert", 1'b0, irq_active_out);
    check_bit("loser alert", 1'b1, irq_active_b);
    $display("test alert response done");
    // released end ignores the next alert response while cause stays
    run_cmd(smb_pkg::CMD_ARA, 7'h00, 8'h00, 8'h00);
    check_bit("ara refused", 1'b1, nack_out);
    check_bit("alert stays off", 1'b0, irq_active_out);
    irq_cause_in = 1'b0;
    idle(10);
    irq_cause_in = 1'b1;
    idle(10);
    check_bit("alert again", 1'b1, irq_active_out);
    $display("test re-arm done");
    // broadcast write to the interrupt control register
    run_cmd(smb_pkg::CMD_WRITE, 7'h30, 8'hfa, 8'h40);
    check_bit("write nack", 1'b0, nack_out);
    check_byte("written reg", 8'h40, regs[5'h1a]);
    idle(10);
    check_byte("pointer after stop", 8'h00, {3'h0, rd_addr_out});
    check_bit("alert released", 1'b0, irq_active_out);
    $display("test broadcast write done");
    // clear-all through the strapped address, then read it back
    run_cmd(smb_pkg::CMD_WRITE, {3'h2, STRAP_A}, 8'h3a, 8'h80);
    check_bit("clear nack", 1'b0, nack_out);
    idle(10);
    check_bit("alert rearmed", 1'b1, irq_active_out);
    run_cmd(smb_pkg::CMD_READ, {3'h2, STRAP_A}, 8'h1a, 8'h00);
    check_bit("read nack", 1'b0, nack_out);
    check_byte("read data", 8'h80, rd_data_out);
    $display("test read back done");
    summarize();
  end
endmodule : smbus_slave_with_alert_response_bench
